// file: cbtf_defs.svh
`ifndef CBTF_DEFS_SVH
`define CBTF_DEFS_SVH
// =====================================================================
// register byte addresses
`define CBTF_ADDR_TIMING   8'h00
`define CBTF_ADDR_MASK     8'h04
`define CBTF_ADDR_MSG_ID   8'h08
`define CBTF_ADDR_MSG_EID  8'h0c
`define CBTF_ADDR_MATCH    8'h10
`define CBTF_ADDR_STATUS   8'h14
`define CBTF_ADDR_FILT0    8'h40
`define CBTF_FILT_COUNT    16
// =====================================================================
// timing register fields
`define CBTF_TIM_WAKE_BIT  14
`define CBTF_TIM_WMASK     16'h47ff
`define CBTF_TIM_RESET     16'h0000
// =====================================================================
// filter, mask and message register fields, processing time, response codes
`define CBTF_FLT_WMASK     16'hffeb
`define CBTF_MSK_WMASK     16'hffeb
`define CBTF_MSG_WMASK     16'hffeb
`define CBTF_ID_RESET      16'h0000
`define CBTF_INFO_PROC_TQ  4'h2
`define CBTF_RESP_OKAY     2'b00
`define CBTF_RESP_SLVERR   2'b10
`endif

// file: cbtf_pkg.sv
package cbtf_pkg;
	typedef struct packed {
		logic       wake_line_filter_sel;
		logic [2:0] phase_two_length;
		logic       phase_two_time_select;
		logic       triple_sample_sel;
		logic [2:0] phase_one_length;
		logic [2:0] propagation_length;
	} cbtf_timing_type;

	typedef struct packed {
		logic [10:0] standard_identifier;
		logic        flag;
		logic [1:0]  extended_identifier;
	} cbtf_id_type;

	typedef enum logic [1:0] {
		CBTF_IDLE = 2'b00,
		CBTF_RESP = 2'b01
	} cbtf_bus_state_type;
endpackage

// file: cbtf_core.sv
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "cbtf_defs.svh"
module cbtf_core (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        can_rx_line,
	input  wire logic        can_rx_filtered,
	output logic             wake_line,
	output logic [3:0]       phase_one_tq,
	output logic [3:0]       phase_two_tq,
	output logic [3:0]       propagation_tq,
	output logic             triple_sample_sel,
	output logic [15:0]      filter_hits
);
	// =================================================================
	// helpers
	function automatic logic [15:0] apply_write(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] st, input logic [15:0] wm);
		logic [15:0] v;
		v = old;
		if (st[0]) v[7:0] = d[7:0];
		if (st[1]) v[15:8] = d[15:8];
		return v & wm;
	endfunction

	function automatic logic [3:0] seg_len(input logic [2:0] f);
		return {1'b0, f} + 4'h1;
	endfunction

	// =================================================================
	// register state
	logic [15:0] timing_r, timing_nxt;
	logic [15:0] mask_r, mask_nxt;
	logic [15:0] msg_r, msg_nxt;
	logic [15:0] msg_ext_r, msg_ext_nxt;
	logic [15:0] filt_r [`CBTF_FILT_COUNT];
	logic [15:0] filt_nxt [`CBTF_FILT_COUNT];
	logic [1:0]  rx_sync_r, rx_sync_nxt;
	logic [1:0]  rxf_sync_r, rxf_sync_nxt;
	logic [2:0]  rx_hist_r, rx_hist_nxt;
	logic        sample_r, sample_nxt;
	logic        wake_r, wake_nxt;
	logic [15:0] hits_r, hits_nxt;
	cbtf_pkg::cbtf_bus_state_type wst_r, wst_nxt, rst_r, rst_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	cbtf_pkg::cbtf_timing_type tim;
	cbtf_pkg::cbtf_id_type msk, msg;
	logic        wr_go;
	logic        rd_go;
	logic [3:0]  windex, rindex;
	logic        wfilt, rfilt;

	assign tim = cbtf_pkg::cbtf_timing_type'({timing_r[14], timing_r[10:0]});
	assign msk = cbtf_pkg::cbtf_id_type'({mask_r[15:5], mask_r[3], mask_r[1:0]});
	assign msg = cbtf_pkg::cbtf_id_type'({msg_r[15:5], msg_r[3], msg_r[1:0]});

	// =================================================================
	// axi4-lite slave: both addr and data must be present, one cycle answer
	assign s_axi_awready = (wst_r == cbtf_pkg::CBTF_IDLE) && s_axi_awvalid && s_axi_wvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = (rst_r == cbtf_pkg::CBTF_IDLE);
	assign wr_go  = s_axi_awready;
	assign rd_go  = s_axi_arready && s_axi_arvalid;
	assign windex = s_axi_awaddr[5:2];
	assign rindex = s_axi_araddr[5:2];
	assign wfilt  = s_axi_awaddr[7:6] == 2'b01;
	assign rfilt  = s_axi_araddr[7:6] == 2'b01;
	assign s_axi_bvalid = (wst_r == cbtf_pkg::CBTF_RESP);
	assign s_axi_rvalid = (rst_r == cbtf_pkg::CBTF_RESP);
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;

	always_comb begin
		timing_nxt  = timing_r;
		mask_nxt    = mask_r;
		msg_nxt     = msg_r;
		msg_ext_nxt = msg_ext_r;
		filt_nxt    = filt_r;
		wst_nxt     = wst_r;
		bresp_nxt   = bresp_r;
		if (wst_r == cbtf_pkg::CBTF_RESP && s_axi_bready) begin
			wst_nxt = cbtf_pkg::CBTF_IDLE;
		end
		if (wr_go) begin
			wst_nxt   = cbtf_pkg::CBTF_RESP;
			bresp_nxt = `CBTF_RESP_OKAY;
			if (wfilt) begin
				filt_nxt[windex] = apply_write(filt_r[windex], s_axi_wdata, s_axi_wstrb, `CBTF_FLT_WMASK);
			end else begin
				unique case (s_axi_awaddr)
					`CBTF_ADDR_TIMING:  timing_nxt  = apply_write(timing_r, s_axi_wdata, s_axi_wstrb,
						`CBTF_TIM_WMASK);
					`CBTF_ADDR_MASK:    mask_nxt    = apply_write(mask_r, s_axi_wdata, s_axi_wstrb,
						`CBTF_MSK_WMASK);
					`CBTF_ADDR_MSG_ID:  msg_nxt     = apply_write(msg_r, s_axi_wdata, s_axi_wstrb,
						`CBTF_MSG_WMASK);
					`CBTF_ADDR_MSG_EID: msg_ext_nxt = apply_write(msg_ext_r, s_axi_wdata, s_axi_wstrb,
						16'hffff);
					`CBTF_ADDR_MATCH, `CBTF_ADDR_STATUS: bresp_nxt = `CBTF_RESP_SLVERR;
					default: bresp_nxt = `CBTF_RESP_SLVERR;
				endcase
			end
		end
	end

	always_comb begin
		rst_nxt   = rst_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rst_r == cbtf_pkg::CBTF_RESP && s_axi_rready) begin
			rst_nxt = cbtf_pkg::CBTF_IDLE;
		end
		if (rd_go) begin
			rst_nxt   = cbtf_pkg::CBTF_RESP;
			rresp_nxt = `CBTF_RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (rfilt) begin
				rdata_nxt = {16'h0000, filt_r[rindex]};
			end else begin
				unique case (s_axi_araddr)
					`CBTF_ADDR_TIMING:  rdata_nxt = {16'h0000, timing_r};
					`CBTF_ADDR_MASK:    rdata_nxt = {16'h0000, mask_r};
					`CBTF_ADDR_MSG_ID:  rdata_nxt = {16'h0000, msg_r};
					`CBTF_ADDR_MSG_EID: rdata_nxt = {16'h0000, msg_ext_r};
					`CBTF_ADDR_MATCH:   rdata_nxt = {16'h0000, hits_r};
					`CBTF_ADDR_STATUS:  rdata_nxt = {28'h0000000, wake_r, sample_r, rx_hist_r[1:0]};
					default:            rresp_nxt = `CBTF_RESP_SLVERR;
				endcase
			end
		end
	end

	// =================================================================
	// timing: segment lengths in quanta
	always_comb begin
		phase_one_tq   = seg_len(tim.phase_one_length);
		propagation_tq = seg_len(tim.propagation_length);
		if (tim.phase_two_time_select) begin
			phase_two_tq = seg_len(tim.phase_two_length);
		end else if (seg_len(tim.phase_one_length) > `CBTF_INFO_PROC_TQ) begin
			phase_two_tq = seg_len(tim.phase_one_length);
		end else begin
			phase_two_tq = `CBTF_INFO_PROC_TQ;
		end
	end
	assign triple_sample_sel = tim.triple_sample_sel;

	// =================================================================
	// bus line sampling and wake path; bus inputs are asynchronous
	always_comb begin
		rx_sync_nxt  = {rx_sync_r[0], can_rx_line};
		rxf_sync_nxt = {rxf_sync_r[0], can_rx_filtered};
		rx_hist_nxt  = {rx_hist_r[1:0], rx_sync_r[1]};
		// majority of three vs latest sample
		if (tim.triple_sample_sel) begin
			sample_nxt = (rx_hist_r[0] & rx_hist_r[1]) | (rx_hist_r[0] & rx_hist_r[2])
				| (rx_hist_r[1] & rx_hist_r[2]);
		end else begin
			sample_nxt = rx_hist_r[0];
		end
		wake_nxt = tim.wake_line_filter_sel ? rxf_sync_r[1] : rx_sync_r[1];
	end
	assign wake_line = wake_r;

	// =================================================================
	// acceptance filtering, registered per filter
	always_comb begin
		cbtf_pkg::cbtf_id_type f;
		logic ok;
		f = '0;
		ok = 1'b0;
		for (int i = 0; i < `CBTF_FILT_COUNT; i++) begin
			f  = cbtf_pkg::cbtf_id_type'({filt_r[i][15:5], filt_r[i][3], filt_r[i][1:0]});
			ok = (((f.standard_identifier ^ msg.standard_identifier) & msk.standard_identifier)
				== 11'h000);
			ok = ok && (((f.extended_identifier ^ msg.extended_identifier)
				& msk.extended_identifier) == 2'b00);
			if (msk.flag) begin
				ok = ok && (f.flag == msg.flag);
			end
			hits_nxt[i] = ok;
		end
	end
	assign filter_hits = hits_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing_r   <= `CBTF_TIM_RESET;
			mask_r     <= `CBTF_ID_RESET;
			msg_r      <= `CBTF_ID_RESET;
			msg_ext_r  <= `CBTF_ID_RESET;
			for (int i = 0; i < `CBTF_FILT_COUNT; i++) filt_r[i] <= `CBTF_ID_RESET;
			rx_sync_r  <= 2'b11;
			rxf_sync_r <= 2'b11;
			rx_hist_r  <= 3'b111;
			sample_r   <= 1'b1;
			wake_r     <= 1'b1;
			hits_r     <= 16'h0000;
			wst_r      <= cbtf_pkg::CBTF_IDLE;
			rst_r      <= cbtf_pkg::CBTF_IDLE;
			rdata_r    <= 32'h0000_0000;
			bresp_r    <= `CBTF_RESP_OKAY;
			rresp_r    <= `CBTF_RESP_OKAY;
		end else begin
			timing_r   <= timing_nxt;
			mask_r     <= mask_nxt;
			msg_r      <= msg_nxt;
			msg_ext_r  <= msg_ext_nxt;
			filt_r     <= filt_nxt;
			rx_sync_r  <= rx_sync_nxt;
			rxf_sync_r <= rxf_sync_nxt;
			rx_hist_r  <= rx_hist_nxt;
			sample_r   <= sample_nxt;
			wake_r     <= wake_nxt;
			hits_r     <= hits_nxt;
			wst_r      <= wst_nxt;
			rst_r      <= rst_nxt;
			rdata_r    <= rdata_nxt;
			bresp_r    <= bresp_nxt;
			rresp_r    <= rresp_nxt;
		end
	end

	// =================================================================
	// checks
	chk_phase_two_free: assert property (@(posedge aclk) disable iff (!aresetn)
		tim.phase_two_time_select |-> phase_two_tq == {1'b0, timing_r[10:8]} + 4'h1)
		else $error("phase two length wrong");
	chk_phase_two_max: assert property (@(posedge aclk) disable iff (!aresetn)
		!tim.phase_two_time_select |-> phase_two_tq == ((phase_one_tq > `CBTF_INFO_PROC_TQ) ? phase_one_tq
		: `CBTF_INFO_PROC_TQ))
		else $error("phase two not the maximum");
	chk_phase_one_len: assert property (@(posedge aclk) disable iff (!aresetn)
		phase_one_tq == {1'b0, timing_r[5:3]} + 4'h1) else $error("phase one length wrong");
	chk_prop_len: assert property (@(posedge aclk) disable iff (!aresetn)
		propagation_tq == {1'b0, timing_r[2:0]} + 4'h1) else $error("propagation length wrong");
	chk_wake_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
		(!tim.wake_line_filter_sel && $stable(tim.wake_line_filter_sel)) |=> wake_line == $past(rx_sync_r[1]))
		else $error("wake path not bypassing filter");
	chk_single_sample: assert property (@(posedge aclk) disable iff (!aresetn)
		!tim.triple_sample_sel |=> sample_r == $past(rx_hist_r[0])) else $error("single sample wrong");
	chk_triple_vote: assert property (@(posedge aclk) disable iff (!aresetn)
		tim.triple_sample_sel |=> sample_r == ($countones($past(rx_hist_r)) >= 2))
		else $error("triple sample vote wrong");
	chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(timing_r & ~`CBTF_TIM_WMASK) == 16'h0000 && (mask_r & ~`CBTF_MSK_WMASK) == 16'h0000)
		else $error("reserved bits not zero");
	chk_filter_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		mask_r == `CBTF_MSK_WMASK |=> filter_hits[0] == ($past(filt_r[0]) == $past(msg_r)))
		else $error("filter 0 match wrong");
	chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_axi_bvalid) else $error("missing write response");
	cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_go);
	cov_read: cover property (@(posedge aclk) disable iff (!aresetn) rd_go);
	cov_hit: cover property (@(posedge aclk) disable iff (!aresetn) filter_hits != 16'h0000);
	cov_triple: cover property (@(posedge aclk) disable iff (!aresetn) tim.triple_sample_sel);
endmodule

// file: cbtf_bus_model.sv
`timescale 1ns/1ps
// =====================================
// far node on the bus: raw line may carry a glitch that the filtered copy lacks
module cbtf_bus_model (
	input  wire logic bus_level,
	input  wire logic glitch_en,
	output logic      can_rx_line,
	output logic      can_rx_filtered
);
	// raw copy inverted while glitching so the two paths are told apart
	assign can_rx_line     = glitch_en ? ~bus_level : bus_level;
	assign can_rx_filtered = bus_level;
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "cbtf_defs.svh"
module testbench;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0, p1, p2, pr;
	logic awready, wready, bvalid, arready, rvalid, rx, rxf, wake, tri_s, lvl = 0, glt = 0;
	logic [1:0] bresp, rresp, rs;
	logic [15:0] hits, t, m, k, hx;
	logic [15:0] f [16];
	logic [31:0] d;
	int err_count = 0, tests_run = 0, cyc = 0;
	always #50 aclk = ~aclk;
	cbtf_bus_model i_cbtf_bus_model (.bus_level(lvl), .glitch_en(glt), .can_rx_line(rx), .can_rx_filtered(rxf));
	cbtf_core i_cbtf_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_rx_line(rx),
		.can_rx_filtered(rxf), .wake_line(wake), .phase_one_tq(p1), .phase_two_tq(p2),
		.propagation_tq(pr), .triple_sample_sel(tri_s), .filter_hits(hits));
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
		logic aw_t, w_t;
		aw_t = 0;
		w_t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'($urandom), v};
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_t && w_t)) begin
			@(posedge aclk);
			if (awready && awvalid) begin
				aw_t = 1;
				awvalid <= 0;
			end
			if (wready && wvalid) begin
				w_t = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		v = rdata;
		r = rresp;
		rready <= 0;
	endtask
	function automatic logic [3:0] ph2_exp(input logic [15:0] v);
		logic [3:0] q;
		q = {1'b0, v[5:3]} + 4'h1;
		if (v[7]) return {1'b0, v[10:8]} + 4'h1;
		return (q > `CBTF_INFO_PROC_TQ) ? q : `CBTF_INFO_PROC_TQ;
	endfunction
	function automatic logic hit_exp(input logic [15:0] fv, input logic [15:0] mv, input logic [15:0] kv);
		return (((fv ^ mv) & kv & 16'hffe3) == 16'h0000) && (!kv[3] || fv[3] == mv[3]);
	endfunction
	initial begin
		void'($urandom(55));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		// ==============================
		// timing fields, corner words then random
		for (int i = 0; i < 24; i++) begin
			t = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : (i == 2) ? 16'h0038 : 16'($urandom);
			axw(`CBTF_ADDR_TIMING, t, rs);
			chk_val("timing wr resp", `CBTF_RESP_OKAY, rs);
			axr(`CBTF_ADDR_TIMING, d, rs);
			chk_val("timing rd", {16'h0, t & `CBTF_TIM_WMASK}, d);
			chk_val("phase one", {1'b0, t[5:3]} + 4'h1, p1);
			chk_val("propagation", {1'b0, t[2:0]} + 4'h1, pr);
			chk_val("phase two", ph2_exp(t), p2);
			chk_val("triple sample", t[6], tri_s);
		end
		// ==============================
		// wake path: raw and filtered copies disagree
		for (int s = 0; s < 2; s++) begin
			axw(`CBTF_ADDR_TIMING, s[0] ? 16'h4000 : 16'h0000, rs);
			lvl <= 1;
			glt <= 1;
			repeat (6) @(posedge aclk);
			chk_val("wake line", s[0], wake);
		end
		glt <= 0;
		// ==============================
		// status: random line activity, single then triple sampling, then a settled level
		for (int s = 0; s < 4; s++) begin
			axw(`CBTF_ADDR_TIMING, s[1] ? 16'h0040 : 16'h0000, rs);
			repeat (12) begin
				@(posedge aclk);
				lvl <= 1'($urandom);
			end
			@(posedge aclk);
			lvl <= s[0];
			repeat (8) @(posedge aclk);
			axr(`CBTF_ADDR_STATUS, d, rs);
			chk_val("status", {28'h0, {4{s[0]}}}, d);
		end
		k = 16'($urandom);
		axw(`CBTF_ADDR_MSG_EID, k, rs);
		axr(`CBTF_ADDR_MSG_EID, d, rs);
		chk_val("message ext rd", {16'h0, k}, d);
		// ==============================
		// sixteen filters against one message, three masks
		for (int r = 0; r < 3; r++) begin
			k = (r == 0) ? 16'hffeb : (r == 1) ? 16'h0000 : 16'($urandom);
			m = 16'($urandom);
			axw(`CBTF_ADDR_MASK, k, rs);
			axw(`CBTF_ADDR_MSG_ID, m, rs);
			m = m & `CBTF_MSG_WMASK;
			k = k & `CBTF_MSK_WMASK;
			for (int i = 0; i < 16; i++) begin
				case (i % 4)
					0: f[i] = m;
					1: f[i] = m ^ (16'h0020 << (i % 11));
					2: f[i] = m ^ (i[3] ? 16'h0001 : 16'h0002);
					default: f[i] = m ^ 16'h0008;
				endcase
				if (r == 2 && i > 11) f[i] = 16'($urandom);
				axw(`CBTF_ADDR_FILT0 + 8'(4 * i), f[i], rs);
				f[i] = f[i] & `CBTF_FLT_WMASK;
				axr(`CBTF_ADDR_FILT0 + 8'(4 * i), d, rs);
				chk_val("filter rd", {16'h0, f[i]}, d);
				hx[i] = hit_exp(f[i], m, k);
			end
			repeat (3) @(posedge aclk);
			chk_val("filter hits", hx, hits);
		end
		// ==============================
		// refused places
		axw(`CBTF_ADDR_MATCH, 16'h1234, rs);
		chk_val("ro write resp", `CBTF_RESP_SLVERR, rs);
		axr(8'h3c, d, rs);
		chk_val("unmapped resp", `CBTF_RESP_SLVERR, rs);
		chk_val("unmapped data", 32'h0, d);
		wrap_up();
	end
endmodule
